/* rtl/slrx_defs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SLRX_DEFS_SVH
`define SLRX_DEFS_SVH
`define SLRX_OFS_ENABLE 10'h100
`define SLRX_OFS_LINK_CONTROL 10'h103
`define SLRX_OFS_SYNC_WORD_MODE 10'h104
`define SLRX_OFS_KM1 10'h105
`define SLRX_OFS_RBD 10'h106
`define SLRX_OFS_STATUS 10'h107
`define SLRX_RST_ENABLE 8'h00
`define SLRX_RST_LINK_CONTROL 8'h03
`define SLRX_RST_SYNC_WORD_MODE 8'h00
`define SLRX_RST_KM1 8'h1F
`define SLRX_RST_RBD 8'h00
`define SLRX_BIT_SCR 0
`define SLRX_BIT_SFMT 1
`define SLRX_BIT_ENC 4
`define SLRX_BIT_SUBCL 5
`define SLRX_BIT_COMPAT 6
`define SLRX_BIT_EBERR 7
`define SLRX_BIT_LINKUP 6
`define SLRX_OCTETS_PER_RBD 4
`define SLRX_K_64B_NUM 256
`endif

/* rtl/slrx_pkg.sv */
// Types shared by the receive-link configuration block.
package slrx_pkg;
  // Link-layer encoding choice.
  typedef enum logic {
    SLRX_ENC_8B10B = 1'b0,
    SLRX_ENC_64B66B = 1'b1
  } slrx_enc_t;
  // Elastic buffer release state.
  typedef enum logic [2:0] {
    SLRX_ST_RESET = 3'b001,
    SLRX_ST_WAIT = 3'b010,
    SLRX_ST_UP = 3'b100
  } slrx_state_t;
endpackage

/* rtl/slrx_lmfc_counter.sv */
// Multiframe (LMFC/LEMC) octet counter producing release opportunities.
`timescale 1ns/1ps
`include "slrx_defs.svh"
module slrx_lmfc_counter
  import slrx_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Control.
  input wire logic hold_reset,
  input wire logic octet_tick,
  input wire logic [CW-1:0] period_octets,
  input wire logic [CW-1:0] delay_octets,
  // Result.
  output logic release_opp
);
  logic [CW-1:0] count_reg;

  // Counts octets of the multiframe; held at zero while disabled.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (hold_reset) begin
      count_reg <= '0;
    end else if (octet_tick) begin
      if (count_reg >= period_octets - 1'b1) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // Flags the opportunity once the count reaches the delayed point.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      release_opp <= 1'b0;
    end else begin
      release_opp <= !hold_reset && octet_tick &&
                     (count_reg == delay_octets);
    end
  end
endmodule

/* rtl/slrx_config_regs.sv */
// Receive serial-link configuration registers and buffer release control.
//
// Contract
// - Bit 6 selects vendor compatibility mode.
// - Subclass 0 releases when all enabled lanes write.
// - Subclass 1 releases on delayed multiframe opportunity.
// - Bit 4 selects 8b/10b or 64b/66b.
// - Bit 1 selects offset binary or two's complement.
// - Bit 0 enables 8b/10b descrambling.
// - 64b/66b always descrambles, ignoring enable.
// - Sync header mode 0 means CRC-12.
// - Sync header mode acts only in 64b/66b.
// - Ignore all sync word command fields.
// - 64b/66b uses K equal 256*E/F.
// - Release delay steps four octets each.
// - Disabled holds link and counter in reset.
// - Sticky buffer error, write one clears.
// - Link-up flag set with buffer release.
`timescale 1ns/1ps
`include "slrx_defs.svh"
module slrx_config_regs
  import slrx_pkg::*;
#(
  parameter int LANES = 16,
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port, one access per cycle.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Link datapath status, from pins or another domain.
  input wire logic [LANES-1:0] lane_writing_async,
  input wire logic [LANES-1:0] lane_enabled,
  input wire logic eb_fault_async,
  input wire logic octet_tick,
  input wire logic [7:0] octets_per_frame,
  input wire logic [7:0] multiblocks_e,
  // Decoded configuration to the datapath.
  output logic link_interface_enable,
  output logic link_subsys_reset,
  output logic phy_enable,
  output logic vendor_compat_mode,
  output logic link_layer_encoding_select,
  output logic sample_format_select,
  output logic descramble_enable,
  output logic crc12_check_enable,
  output logic sync_cmd_ignore,
  output logic [CW-1:0] multiframe_octets,
  output logic buffer_release,
  output logic link_up
);
  // Link interface enable register; only bit 0 acts.
  logic [7:0] enable_reg;
  // Link control: compat mode, subclass, encoding, format, scrambler.
  logic [7:0] link_control_reg;
  // Sync word mode; the low two bits pick the sync header use.
  logic [7:0] sync_word_mode_reg;
  // Frames per multiframe minus one, used with 8b/10b only.
  logic [7:0] km1_reg;
  // Release buffer delay in steps of four octets.
  logic [7:0] rbd_reg;
  // Sticky elastic buffer error, cleared by writing a one.
  logic elastic_buffer_error_flag;
  // First synchroniser stage for lane activity.
  logic [LANES-1:0] lane_s1_reg;
  // Second synchroniser stage for lane activity; the only one read.
  logic [LANES-1:0] lane_s2_reg;
  // First synchroniser stage for the buffer fault.
  logic eb_s1_reg;
  // Second synchroniser stage for the buffer fault.
  logic eb_s2_reg;
  // Elastic buffer release state.
  slrx_state_t state_reg;
  // One-cycle release opportunity from the multiframe counter.
  logic release_opp;
  // High when every enabled lane has begun writing.
  logic all_lanes;
  // Multiframe length in octets for the current settings.
  logic [CW-1:0] period_next;
  // Release delay converted to octets.
  logic [CW-1:0] delay_octets;
  // Link interface enable as a single bit.
  logic en;

  // Picks the multiframe length in octets for the current encoding.
  function automatic logic [CW-1:0] calc_period(
    input logic enc, input logic [7:0] km1, input logic [7:0] f,
    input logic [7:0] e);
    // Eight spare bits so the product cannot wrap before the cut.
    logic [CW+7:0] p;
    p = '0;
    if (enc == SLRX_ENC_64B66B) begin
      // The K register is ignored here; K times F reduces to 256 times E.
      p = (CW+8)'(`SLRX_K_64B_NUM) * (CW+8)'(e);
    end else begin
      // The programmed K times the octets in one frame.
      p = (CW+8)'({1'b0, km1} + 9'h001) * (CW+8)'(f);
    end
    // Legal settings fit in CW bits, so the upper bits are dropped.
    return p[CW-1:0];
  endfunction

  // The whole link follows bit 0 of the enable register.
  assign en = enable_reg[0];
  // Disabled lanes never hold back the release.
  // Only synchronised activity is looked at.
  assign all_lanes = ((lane_s2_reg & lane_enabled) == lane_enabled);
  // Multiframe length follows the selected encoding.
  assign period_next = calc_period(link_control_reg[`SLRX_BIT_ENC],
                                   km1_reg, octets_per_frame,
                                   multiblocks_e);
  // Each delay step is four octets.
  assign delay_octets = CW'({rbd_reg[5:0], 2'b00});

  // Register writes; software keeps these still while enabled.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Every register starts at its documented default.
      enable_reg <= `SLRX_RST_ENABLE;
      link_control_reg <= `SLRX_RST_LINK_CONTROL;
      sync_word_mode_reg <= `SLRX_RST_SYNC_WORD_MODE;
      km1_reg <= `SLRX_RST_KM1;
      rbd_reg <= `SLRX_RST_RBD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `SLRX_OFS_ENABLE: begin
          // All bits are kept so that software reads back what it wrote.
          enable_reg <= reg_wdata;
        end
        `SLRX_OFS_LINK_CONTROL: begin
          // Taken at any time; software changes it only while disabled.
          link_control_reg <= reg_wdata;
        end
        `SLRX_OFS_SYNC_WORD_MODE: begin
          // Only acts when 64b/66b is selected.
          sync_word_mode_reg <= reg_wdata;
        end
        `SLRX_OFS_KM1: begin
          // An illegal K is the writer's problem; no check is made here.
          km1_reg <= reg_wdata;
        end
        `SLRX_OFS_RBD: begin
          // Only the low six bits feed the release delay.
          rbd_reg <= reg_wdata;
        end
        default: begin
          // Other addresses are not in this block.
        end
      endcase
    end
  end

  // Two-stage synchronisers for lane activity and buffer fault.
  // Only the second stage is read, so a metastable first stage
  // never reaches the release logic.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_s1_reg <= '0;
      lane_s2_reg <= '0;
      eb_s1_reg <= 1'b0;
      eb_s2_reg <= 1'b0;
    end else begin
      // First stages may go metastable; nothing but the next stage reads them.
      lane_s1_reg <= lane_writing_async;
      lane_s2_reg <= lane_s1_reg;
      eb_s1_reg <= eb_fault_async;
      eb_s2_reg <= eb_s1_reg;
    end
  end

  // Sticky buffer error; a new fault beats a clearing write.
  // The flag clears only when software writes a one to bit 7.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      elastic_buffer_error_flag <= 1'b0;
    end else if (eb_s2_reg) begin
      // A fault in the cycle of a clear keeps the flag set.
      elastic_buffer_error_flag <= 1'b1;
    end else if (reg_wr && reg_addr == `SLRX_OFS_STATUS &&
                 reg_wdata[`SLRX_BIT_EBERR]) begin
      elastic_buffer_error_flag <= 1'b0;
    end
  end

  // Multiframe counter, held in reset while disabled.
  // Opportunities come from the counter; the delay shifts them.
  slrx_lmfc_counter #(
    .CW(CW)
  ) u_lmfc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .hold_reset(!en),
    .octet_tick(octet_tick),
    .period_octets(period_next),
    .delay_octets(delay_octets),
    .release_opp(release_opp)
  );

  // Elastic buffer release sequencing.
  // Disabling drops straight back to reset, whatever the state.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SLRX_ST_RESET;
    end else if (!en) begin
      state_reg <= SLRX_ST_RESET;
    end else begin
      unique case (state_reg)
        SLRX_ST_RESET: begin
          // One cycle in reset before the lanes are watched.
          state_reg <= SLRX_ST_WAIT;
        end
        SLRX_ST_WAIT: begin
          // Every enabled lane must have begun writing first.
          if (all_lanes) begin
            if (!link_control_reg[`SLRX_BIT_SUBCL]) begin
              state_reg <= SLRX_ST_UP;
            // Subclass 1 waits for the delayed multiframe point.
            end else if (release_opp) begin
              state_reg <= SLRX_ST_UP;
            end
          end
        end
        SLRX_ST_UP: begin
          // Stays released until the link is disabled.
          state_reg <= SLRX_ST_UP;
        end
        default: begin
          // An illegal code falls back to reset.
          state_reg <= SLRX_ST_RESET;
        end
      endcase
    end
  end

  // Registered decoded outputs to the datapath.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Reset values match the register defaults, except multiframe_octets, which starts at zero.
      link_interface_enable <= 1'b0;
      link_subsys_reset <= 1'b1;
      phy_enable <= 1'b0;
      vendor_compat_mode <= 1'b0;
      link_layer_encoding_select <= 1'b0;
      sample_format_select <= 1'b1;
      descramble_enable <= 1'b1;
      crc12_check_enable <= 1'b0;
      sync_cmd_ignore <= 1'b1;
      multiframe_octets <= '0;
      buffer_release <= 1'b0;
      link_up <= 1'b0;
    end else begin
      link_interface_enable <= en;
      link_subsys_reset <= !en;
      phy_enable <= en;
      vendor_compat_mode <= link_control_reg[`SLRX_BIT_COMPAT];
      link_layer_encoding_select <= link_control_reg[`SLRX_BIT_ENC];
      sample_format_select <= link_control_reg[`SLRX_BIT_SFMT];
      // 64b/66b is always scrambled, so the enable bit is ignored there.
      descramble_enable <= link_control_reg[`SLRX_BIT_ENC] ||
                           link_control_reg[`SLRX_BIT_SCR];
      // CRC-12 only when the mode is 0 and 64b/66b is selected.
      crc12_check_enable <= link_control_reg[`SLRX_BIT_ENC] &&
                            (sync_word_mode_reg[1:0] == 2'h0);
      // Command fields in the sync word are never acted on.
      sync_cmd_ignore <= 1'b1;
      // Octets per multiframe, for the datapath's own counter.
      multiframe_octets <= period_next;
      // Both flags follow the release state one cycle late.
      buffer_release <= (state_reg == SLRX_ST_UP);
      link_up <= (state_reg == SLRX_ST_UP);
    end
  end

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SLRX_OFS_ENABLE: reg_rdata <= enable_reg;
        `SLRX_OFS_LINK_CONTROL: reg_rdata <= link_control_reg;
        `SLRX_OFS_SYNC_WORD_MODE: reg_rdata <= sync_word_mode_reg;
        `SLRX_OFS_KM1: reg_rdata <= km1_reg;
        `SLRX_OFS_RBD: reg_rdata <= rbd_reg;
        // Status packs the error flag and the live release state.
        `SLRX_OFS_STATUS: begin
          reg_rdata <= {elastic_buffer_error_flag,
                        state_reg == SLRX_ST_UP, 6'h00};
        end
        // Unmapped offsets read as zero.
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* bench/slrx_asserts.sv */
// Port checker for the receive-link configuration block.
`timescale 1ns/1ps
module slrx_asserts (
  // Clock, reset and register writes.
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Decoded outputs.
  input wire logic link_interface_enable,
  input wire logic link_subsys_reset,
  input wire logic phy_enable,
  input wire logic vendor_compat_mode,
  input wire logic link_layer_encoding_select,
  input wire logic sample_format_select,
  input wire logic descramble_enable,
  input wire logic crc12_check_enable,
  input wire logic sync_cmd_ignore,
  input wire logic buffer_release,
  input wire logic link_up
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A write to the link control register.
  wire ctl_wr = reg_wr && reg_addr == 10'h103;
  property p_compat;
    ctl_wr |-> ##2 vendor_compat_mode == $past(reg_wdata[6], 2);
  endproperty
  a_compat: assert property (p_compat) else $error("compat bit");
  property p_enc;
    ctl_wr |-> ##2 link_layer_encoding_select == $past(reg_wdata[4], 2);
  endproperty
  a_enc: assert property (p_enc) else $error("encoding bit");
  property p_fmt;
    ctl_wr |-> ##2 sample_format_select == $past(reg_wdata[1], 2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format bit");
  property p_scr64;
    link_layer_encoding_select |-> descramble_enable;
  endproperty
  a_scr64: assert property (p_scr64) else $error("64b descramble");
  property p_crc;
    crc12_check_enable |-> link_layer_encoding_select;
  endproperty
  a_crc: assert property (p_crc) else $error("crc outside 64b");
  property p_cmd;
    sync_cmd_ignore;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not ignored");
  property p_off;
    $fell(link_interface_enable) |->
      ##[0:2] (link_subsys_reset && !phy_enable && !link_up);
  endproperty
  a_off: assert property (p_off) else $error("disable not held");
  property p_up;
    $rose(link_up) |-> buffer_release && link_interface_enable;
  endproperty
  a_up: assert property (p_up) else $error("link up early");
  // Main scenarios reached.
  c_wr: cover property (ctl_wr);
  c_up: cover property ($rose(link_up));
  c_crc: cover property ($rose(crc12_check_enable));
endmodule

/* bench/slrx_tx_model.sv */
// Transmitter stand-in driving lane activity and buffer faults.
`timescale 1ns/1ps
module slrx_tx_model #(
  parameter int LANES = 4
) (
  // Clock and controls from the bench.
  input wire logic core_clk,
  input wire logic go,
  input wire logic slow,
  input wire logic fault,
  // Activity seen by the receiver.
  output logic [LANES-1:0] lane_writing,
  output logic eb_fault
);
  // Scrambled, matching encoding assumed; lanes start together or ripple.
  always @(posedge core_clk) begin
    if (!go) lane_writing <= '0;
    else if (!slow) lane_writing <= '1;
    else lane_writing <= {lane_writing[LANES-2:0], 1'b1};
  end
  // Buffer fault only when the bench asks for it.
  assign eb_fault = fault;
endmodule

/* bench/tb.sv */
// Self-checking bench for the receive-link configuration block.
`timescale 1ns/1ps
module tb;
  logic core_clk, arst_n, reg_wr, reg_rd, eb_f, tick, go, slow, fault;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, opf, mbe, c, km, rb;
  logic [3:0] lw, len;
  logic lie, lsr, phy, vcm, enc, sfs, dsc, crc, sci, brel, lup;
  logic [15:0] mfo;
  int error_cnt, checks, cycles, t0, t1;
  slrx_config_regs #(.LANES(4), .CW(16)) dut (.core_clk, .arst_n,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .lane_writing_async(lw), .lane_enabled(len), .eb_fault_async(eb_f),
    .octet_tick(tick), .octets_per_frame(opf), .multiblocks_e(mbe),
    .link_interface_enable(lie), .link_subsys_reset(lsr),
    .phy_enable(phy), .vendor_compat_mode(vcm),
    .link_layer_encoding_select(enc), .sample_format_select(sfs),
    .descramble_enable(dsc), .crc12_check_enable(crc),
    .sync_cmd_ignore(sci), .multiframe_octets(mfo),
    .buffer_release(brel), .link_up(lup));
  slrx_tx_model #(.LANES(4)) tx (.core_clk, .go, .slow, .fault,
    .lane_writing(lw), .eb_fault(eb_f));
  // Free-running core clock.
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic cyc(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc();
    reg_wr = 0;
    cyc();
  endtask
  // Read data is valid one cycle after the read edge.
  task automatic rd(logic [9:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1;
    cyc();
    reg_rd = 0;
    cyc();
    chk("rdata", exp, reg_rdata);
  endtask
  // Waits for buffer release, counting cycles.
  task automatic wait_rel(output int n);
    n = 0;
    while (brel !== 1'b1 && n < 300) begin
      cyc();
      n++;
    end
  endtask
  function automatic logic [15:0] f_mfo(logic e64, logic [7:0] k,
      logic [7:0] f, logic [7:0] e);
    return e64 ? 16'(256 * e) : 16'((k + 1) * f);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tick, go} = '0;
    {slow, fault, opf, mbe, len} = {2'b00, 8'h04, 8'h01, 4'hF};
    void'($urandom(32'h3074f6e0));
    cyc(8);
    arst_n = 1;
    chk("fmt", 1, sfs);
    chk("dsc", 1, dsc);
    chk("rst", 1, lsr);
    chk("sci", 1, sci);
    rd(10'h103, 8'h03);
    rd(10'h104, 8'h00);
    rd(10'h105, 8'h1F);
    rd(10'h106, 8'h00);
    rd(10'h1F0, 8'h00);
    // Random control values, 64b/66b with scrambler off first.
    for (int i = 0; i < 8; i++) begin
      c = i ? 8'($urandom & 8'h73) : 8'h10;
      km = 8'($urandom % 32);
      opf = 8'(1 + $urandom % 8);
      mbe = 8'(1 + $urandom % 4);
      rb = c[4] ? 8'($urandom % 64) : 8'h00;
      wr(10'h103, c);
      wr(10'h105, km);
      wr(10'h106, rb);
      cyc();
      chk("vcm", c[6], vcm);
      chk("enc", c[4], enc);
      chk("fmt", c[1], sfs);
      chk("dsc", c[0] | c[4], dsc);
      chk("crc", c[4], crc);
      chk("mfo", f_mfo(c[4], km, opf, mbe), mfo);
      rd(10'h103, c);
      rd(10'h106, rb);
    end
    // Subclass 0 with lanes rippling in one by one.
    len = 4'($urandom | 1);
    wr(10'h103, 8'h03);
    slow = 1;
    go = 1;
    wr(10'h100, 8'h01);
    wait_rel(t0);
    chk("rel", 1, brel);
    chk("lie", 1, lie);
    chk("lsr", 0, lsr);
    cyc(2);
    rd(10'h107, 8'h40);
    fault = 1;
    cyc(3);
    fault = 0;
    cyc(3);
    rd(10'h107, 8'hC0);
    wr(10'h107, 8'h80);
    rd(10'h107, 8'h40);
    wr(10'h100, 8'h00);
    cyc();
    chk("up", 0, lup);
    chk("lie", 0, lie);
    chk("phy", 0, phy);
    // Subclass 1: release delay step moves release by four octets.
    tick = 1;
    opf = 8'h04;
    wr(10'h105, 8'h07);
    wr(10'h103, 8'h23);
    wr(10'h106, 8'h02);
    wr(10'h100, 8'h01);
    wait_rel(t0);
    wr(10'h100, 8'h00);
    wr(10'h106, 8'h03);
    wr(10'h100, 8'h01);
    wait_rel(t1);
    chk("rbd", 4, 16'(t1 - t0));
    tally_and_finish();
  end
endmodule
bind slrx_config_regs slrx_asserts u_chk (.core_clk(core_clk),
  .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .link_interface_enable(link_interface_enable),
  .link_subsys_reset(link_subsys_reset), .phy_enable(phy_enable),
  .vendor_compat_mode(vendor_compat_mode),
  .link_layer_encoding_select(link_layer_encoding_select),
  .sample_format_select(sample_format_select),
  .descramble_enable(descramble_enable),
  .crc12_check_enable(crc12_check_enable),
  .sync_cmd_ignore(sync_cmd_ignore), .buffer_release(buffer_release),
  .link_up(link_up));
